// ==== inc/flash_unlock_map.vh ====
// Register map, field positions, reset values and timing for the flash unlock block
`ifndef FLASH_UNLOCK_MAP_VH
`define FLASH_UNLOCK_MAP_VH

// Special function register addresses
`define CTRL_ADDR 8'h50
`define ADDR_LOW_ADDR 8'h54
`define ADDR_HIGH_ADDR 8'h55
`define WORD0_LOW_ADDR 8'h58
`define WORD0_HIGH_ADDR 8'h59
`define WORD1_LOW_ADDR 8'h5A
`define WORD1_HIGH_ADDR 8'h5B
`define WORD2_LOW_ADDR 8'h5C
`define WORD2_HIGH_ADDR 8'h5D
`define WORD3_LOW_ADDR 8'h5E
`define WORD3_HIGH_ADDR 8'h5F
`define DATA_BASE_ADDR 8'h58

// Control register fields
`define CTRL_ENABLED_BIT 7
`define CTRL_MODE_HI 6
`define CTRL_MODE_LO 4
`define CTRL_START_BIT 3
`define CTRL_WRITE_GO_BIT 2
`define CTRL_READ_EN_BIT 1
`define CTRL_READ_GO_BIT 0

// Operation select codes
`define MODE_WRITE 3'h0
`define MODE_ERASE 3'h1
`define MODE_READ 3'h3
`define MODE_UNLOCK 3'h6

// Reset values
`define CTRL_RESET 8'h70
`define ADDR_RESET 8'h00
`define DATA_RESET 8'h00
`define UNMAPPED_READ 8'h00

// Unlock pattern, in the order it must arrive
`define PATTERN_0 8'h00
`define PATTERN_1 8'h04
`define PATTERN_2 8'h0D
`define PATTERN_3 8'h09
`define PATTERN_4 8'hC3
`define PATTERN_5 8'h40
`define PATTERN_LEN 3'h6

// Unlock timeout
`define UNLOCK_TIMEOUT_US 300
`define US_PER_S 1000000

`endif

// ==== core/flash_data_regs.v ====
// Eight byte register file for the four flash data words, registered read port
`timescale 1ns/1ps
module flash_data_regs (
   // Clock and reset
   input wire clock_i,
   input wire resetn_i,
   // Write port
   input wire wr_i,
   input wire [2:0] waddr_i,
   input wire [7:0] wdata_i,
   // Read port
   input wire [2:0] raddr_i,
   output reg [7:0] rdata_o
);
`include "flash_unlock_map.vh"

   reg [7:0] mem [0:7];
   integer i;

   always @(posedge clock_i) begin
      if (!resetn_i) begin
         for (i = 0; i < 8; i = i + 1) begin
            mem[i] <= `DATA_RESET;
         end
         rdata_o <= `DATA_RESET;
      end else begin
         if (wr_i) begin
            mem[waddr_i] <= wdata_i;
         end
         rdata_o <= mem[raddr_i];
      end
   end
endmodule

// ==== core/flash_unlock.v ====
// Flash write unlock sequencer, control/address registers and erase numbering
// Functional notes
// - Four 16-bit data words are kept, each as a readable and writable low and high byte.
// - The start bit is set by software and is accepted in the same write as the mode code.
// - Starting the procedure starts a 300 us timeout inside which the pattern must arrive.
// - The timeout counts ticks of the low speed internal oscillator, not the system clock.
// - On timeout or a wrong byte writing stays disabled and the start bit self-clears.
// - A correct pattern in time enables writing, clears the start bit and sets the flag.
// - Flash writes and erases are only passed on while the write enabled flag is set.
// - Software clearing the write enabled flag disables flash writing.
// - The smallest variant erases 256-word blocks numbered by address high bits 3..0 only.
// - Larger variants erase 32 or 64 word pages numbered by address high and low upper bits.
// - Writing a one to the write enabled flag does nothing; only hardware sets it.
// - Once enabled, writing stays enabled without the start bit until the flag is cleared.
`timescale 1ns/1ps
module flash_unlock #(
   parameter PAGE_WORDS = 256,
   parameter ADDR_HIGH_BITS = 4,
   parameter LOW_SPEED_INTERNAL_OSC_HZ = 32000
) (
   // Clock and reset
   input wire clock_i,
   input wire resetn_i,
   // Special function register port
   input wire [7:0] sfr_addr_i,
   input wire [7:0] sfr_wdata_i,
   input wire sfr_wr_i,
   input wire sfr_rd_i,
   output reg [7:0] sfr_rdata_o,
   output reg sfr_rvalid_o,
   // Low speed oscillator, asynchronous
   input wire low_speed_internal_osc_i,
   // Flash array side
   input wire flash_done_i,
   output reg flash_write_req_o,
   output reg flash_erase_req_o,
   output reg [9:0] erase_number_o,
   // Status
   output reg write_enabled_o,
   output reg unlock_busy_o
);
`include "flash_unlock_map.vh"

   localparam OFFSET_BITS = (PAGE_WORDS == 256) ? 8 : ((PAGE_WORDS == 64) ? 6 : 5);
   localparam integer TIMEOUT_TICKS_RAW = (`UNLOCK_TIMEOUT_US * LOW_SPEED_INTERNAL_OSC_HZ) / `US_PER_S;
   localparam [15:0] TIMEOUT_TICKS = (TIMEOUT_TICKS_RAW < 1) ? 16'h0001 :
      TIMEOUT_TICKS_RAW[15:0];
   localparam [7:0] HIGH_MASK = (8'hFF >> (8 - ADDR_HIGH_BITS));
   localparam [7:0] DATA_BASE = `DATA_BASE_ADDR;

   localparam ST_IDLE = 1'b0;
   localparam ST_ARMED = 1'b1;

   // Erase unit number: address bits above the in-block/in-page offset
   function [9:0] erase_index;
      input [7:0] high;
      input [7:0] low;
      reg [17:0] full;
      begin
         // Two spare top bits keep the 10-bit slice inside the word for 256-word blocks
         full = {2'b00, high & HIGH_MASK, low};
         erase_index = full[OFFSET_BITS +: 10];
      end
   endfunction

   // Expected pattern byte for a step
   function [7:0] pattern_byte;
      input [2:0] step;
      begin
         case (step)
            3'h0: pattern_byte = `PATTERN_0;
            3'h1: pattern_byte = `PATTERN_1;
            3'h2: pattern_byte = `PATTERN_2;
            3'h3: pattern_byte = `PATTERN_3;
            3'h4: pattern_byte = `PATTERN_4;
            default: pattern_byte = `PATTERN_5;
         endcase
      end
   endfunction

   reg [7:0] ctrl;
   reg [7:0] addr_low;
   reg [7:0] addr_high;
   reg state;
   reg [2:0] step;
   reg [15:0] tick_count;
   reg [2:0] osc_sync;
   reg osc_level;
   reg rd_pending;
   reg [7:0] rd_addr;

   wire [7:0] mem_rdata;
   wire data_sel = (sfr_addr_i[7:3] == DATA_BASE[7:3]);
   wire data_wr = sfr_wr_i && data_sel;
   wire ctrl_wr = sfr_wr_i && (sfr_addr_i == `CTRL_ADDR);
   wire [2:0] new_mode = sfr_wdata_i[`CTRL_MODE_HI:`CTRL_MODE_LO];
   wire [2:0] cur_mode = ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO];
   // Pattern goes to word1 low .. word3 high, i.e. data index 2..7
   wire pattern_reg = data_wr && (sfr_addr_i[2:0] >= 3'h2);
   wire pattern_hit = (sfr_addr_i[2:0] == step + 3'h2) &&
      (sfr_wdata_i == pattern_byte(step));

   // Oscillator edge seen once second and third stages agree
   wire osc_stable = (osc_sync[1] == osc_sync[2]);
   wire osc_tick = osc_stable && osc_sync[1] && !osc_level;
   wire timed_out = (tick_count >= TIMEOUT_TICKS);

   flash_data_regs u_data (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .wr_i(data_wr),
      .waddr_i(sfr_addr_i[2:0]),
      .wdata_i(sfr_wdata_i),
      .raddr_i(sfr_addr_i[2:0]),
      .rdata_o(mem_rdata)
   );

   always @(posedge clock_i) begin
      if (!resetn_i) begin
         osc_sync <= 3'h0;
         osc_level <= 1'b0;
      end else begin
         osc_sync <= {osc_sync[1:0], low_speed_internal_osc_i};
         if (osc_stable) begin
            osc_level <= osc_sync[1];
         end
      end
   end

   // Unlock sequencer and control register
   always @(posedge clock_i) begin
      if (!resetn_i) begin
         ctrl <= `CTRL_RESET;
         state <= ST_IDLE;
         step <= 3'h0;
         tick_count <= 16'h0000;
         flash_write_req_o <= 1'b0;
         flash_erase_req_o <= 1'b0;
      end else begin
         flash_write_req_o <= 1'b0;
         flash_erase_req_o <= 1'b0;
         if (ctrl_wr) begin
            ctrl[6:0] <= sfr_wdata_i[6:0];
            // Writing one to the flag is ignored
            if (!sfr_wdata_i[`CTRL_ENABLED_BIT]) begin
               ctrl[`CTRL_ENABLED_BIT] <= 1'b0;
            end
            if (sfr_wdata_i[`CTRL_WRITE_GO_BIT] && !ctrl[`CTRL_WRITE_GO_BIT]) begin
               if (ctrl[`CTRL_ENABLED_BIT] && sfr_wdata_i[`CTRL_ENABLED_BIT] &&
                     (new_mode == `MODE_WRITE || new_mode == `MODE_ERASE)) begin
                  flash_write_req_o <= (new_mode == `MODE_WRITE);
                  flash_erase_req_o <= (new_mode == `MODE_ERASE);
               end else begin
                  ctrl[`CTRL_WRITE_GO_BIT] <= 1'b0;
               end
            end
         end
         if (flash_done_i) begin
            ctrl[`CTRL_WRITE_GO_BIT] <= 1'b0;
         end
         case (state)
            ST_IDLE: begin
               // Mode and start may arrive in one write
               if (ctrl_wr && sfr_wdata_i[`CTRL_START_BIT] && new_mode == `MODE_UNLOCK) begin
                  state <= ST_ARMED;
                  step <= 3'h0;
                  tick_count <= 16'h0000;
               end
            end
            ST_ARMED: begin
               if (osc_tick) begin
                  tick_count <= tick_count + 16'h0001;
               end
               if (ctrl_wr && (!sfr_wdata_i[`CTRL_START_BIT] || new_mode != `MODE_UNLOCK)) begin
                  // Software withdrew the attempt
                  state <= ST_IDLE;
               end else if (timed_out) begin
                  state <= ST_IDLE;
                  ctrl[`CTRL_START_BIT] <= 1'b0;
               end else if (pattern_reg) begin
                  if (!pattern_hit) begin
                     state <= ST_IDLE;
                     ctrl[`CTRL_START_BIT] <= 1'b0;
                  end else if (step == `PATTERN_LEN - 3'h1) begin
                     state <= ST_IDLE;
                     ctrl[`CTRL_START_BIT] <= 1'b0;
                     ctrl[`CTRL_ENABLED_BIT] <= 1'b1;
                  end else begin
                     step <= step + 3'h1;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Address registers and erase numbering
   always @(posedge clock_i) begin
      if (!resetn_i) begin
         addr_low <= `ADDR_RESET;
         addr_high <= `ADDR_RESET;
         erase_number_o <= 10'h000;
      end else begin
         if (sfr_wr_i && sfr_addr_i == `ADDR_LOW_ADDR) begin
            addr_low <= sfr_wdata_i;
         end
         if (sfr_wr_i && sfr_addr_i == `ADDR_HIGH_ADDR) begin
            // Unimplemented high bits read back as zero
            addr_high <= sfr_wdata_i & HIGH_MASK;
         end
         erase_number_o <= erase_index(addr_high, addr_low);
      end
   end

   // Read path: two cycles so memory and control reads line up
   always @(posedge clock_i) begin
      if (!resetn_i) begin
         rd_pending <= 1'b0;
         rd_addr <= 8'h00;
         sfr_rdata_o <= `UNMAPPED_READ;
         sfr_rvalid_o <= 1'b0;
         write_enabled_o <= 1'b0;
         unlock_busy_o <= 1'b0;
      end else begin
         rd_pending <= sfr_rd_i;
         rd_addr <= sfr_addr_i;
         sfr_rvalid_o <= rd_pending;
         write_enabled_o <= ctrl[`CTRL_ENABLED_BIT];
         unlock_busy_o <= (state == ST_ARMED);
         if (rd_pending) begin
            if (rd_addr[7:3] == DATA_BASE[7:3]) begin
               sfr_rdata_o <= mem_rdata;
            end else if (rd_addr == `CTRL_ADDR) begin
               sfr_rdata_o <= ctrl;
            end else if (rd_addr == `ADDR_LOW_ADDR) begin
               sfr_rdata_o <= addr_low;
            end else if (rd_addr == `ADDR_HIGH_ADDR) begin
               sfr_rdata_o <= addr_high;
            end else begin
               sfr_rdata_o <= `UNMAPPED_READ;
            end
         end
      end
   end
endmodule

// ==== dv/flash_unlock_properties.sv ====
// Port-level checks for the flash unlock block
`timescale 1ns/1ps
module flash_unlock_properties #(
   parameter PAGE_WORDS = 256
) (
   // Clock and reset
   input wire clock_i,
   input wire resetn_i,
   // Register port
   input wire [7:0] sfr_addr_i,
   input wire [7:0] sfr_wdata_i,
   input wire sfr_wr_i,
   input wire sfr_rd_i,
   input wire [7:0] sfr_rdata_o,
   input wire sfr_rvalid_o,
   // Oscillator and flash side
   input wire low_speed_internal_osc_i,
   input wire flash_done_i,
   input wire flash_write_req_o,
   input wire flash_erase_req_o,
   input wire [9:0] erase_number_o,
   // Status
   input wire write_enabled_o,
   input wire unlock_busy_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   wire ctrl_wr = sfr_wr_i && sfr_addr_i == 8'h50;
   wire arm_wr = ctrl_wr && sfr_wdata_i[6:3] == 4'hD;
   wire clr_wr = ctrl_wr && !sfr_wdata_i[7];
   AST_READ_LATENCY: assert property (sfr_rd_i |-> ##2 sfr_rvalid_o)
      else $error("read answer missing");
   // Busy follows the state register, two edges after arming; a repeated arm is left out
   AST_ARM: assert property (arm_wr && !unlock_busy_o && !write_enabled_o
      && !$past(arm_wr) |-> ##2 unlock_busy_o)
      else $error("arming write not taken");
   AST_ENABLE_CAUSE: assert property ($rose(write_enabled_o) |->
      $past(sfr_wr_i, 2) && $past(unlock_busy_o, 2) && $past(sfr_addr_i, 2) == 8'h5F &&
      $past(sfr_wdata_i, 2) == 8'h40)
      else $error("enable set without last pattern byte");
   AST_DISABLE: assert property (clr_wr |-> ##2 !write_enabled_o)
      else $error("enable not cleared");
   AST_HOLD: assert property (write_enabled_o && !clr_wr && !$past(clr_wr)
      |=> write_enabled_o)
      else $error("enable lost");
   AST_ERASE_BLOCK: assert property (PAGE_WORDS == 256 && sfr_wr_i
      && sfr_addr_i == 8'h55 |-> ##2 erase_number_o == {6'h00, $past(sfr_wdata_i[3:0], 2)})
      else $error("block number wrong");
   AST_CMD_GUARD: assert property (flash_write_req_o || flash_erase_req_o
      |-> $past(write_enabled_o))
      else $error("flash command while disabled");
   AST_ERASE_CAUSE: assert property (flash_erase_req_o
      |-> $past(ctrl_wr && sfr_wdata_i[6:4] == 3'h1 && sfr_wdata_i[2]))
      else $error("erase without erase command");
   cover property ($rose(write_enabled_o));
   cover property ($fell(unlock_busy_o) && !write_enabled_o);
   cover property (flash_erase_req_o);
endmodule

bind flash_unlock flash_unlock_properties #(.PAGE_WORDS(PAGE_WORDS)) u_props (
   .clock_i(clock_i), .resetn_i(resetn_i), .sfr_addr_i(sfr_addr_i),
   .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
   .sfr_rdata_o(sfr_rdata_o), .sfr_rvalid_o(sfr_rvalid_o),
   .low_speed_internal_osc_i(low_speed_internal_osc_i), .flash_done_i(flash_done_i),
   .flash_write_req_o(flash_write_req_o), .flash_erase_req_o(flash_erase_req_o),
   .erase_number_o(erase_number_o), .write_enabled_o(write_enabled_o),
   .unlock_busy_o(unlock_busy_o));

// ==== dv/flash_unlock_bench.sv ====
// Self-checking bench for the flash unlock block
`timescale 1ns/1ps
module flash_unlock_bench;
   localparam [47:0] PAT = 48'h00040D09C340;
   reg clock_i = 1'b0;
   reg resetn_i = 1'b0;
   reg [7:0] sfr_addr_i = 8'h00;
   reg [7:0] sfr_wdata_i = 8'h00;
   reg sfr_wr_i = 1'b0;
   reg sfr_rd_i = 1'b0;
   reg low_speed_internal_osc_i = 1'b0;
   reg flash_done_i = 1'b0;
   wire [7:0] sfr_rdata_o;
   wire sfr_rvalid_o, flash_write_req_o, flash_erase_req_o, write_enabled_o, unlock_busy_o;
   wire [9:0] erase_number_o;
   integer n_mismatch = 0;
   integer n_tests = 0;
   integer i;
   reg [7:0] q [$];
   reg [7:0] v, h;
   always #12.5 clock_i = ~clock_i;
   // Oscillator period of 20 system cycles keeps the timeout short
   always begin
      repeat (10) @(posedge clock_i);
      low_speed_internal_osc_i <= ~low_speed_internal_osc_i;
   end
   flash_unlock DUT (.clock_i(clock_i), .resetn_i(resetn_i), .sfr_addr_i(sfr_addr_i),
      .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
      .sfr_rdata_o(sfr_rdata_o), .sfr_rvalid_o(sfr_rvalid_o),
      .low_speed_internal_osc_i(low_speed_internal_osc_i), .flash_done_i(flash_done_i),
      .flash_write_req_o(flash_write_req_o), .flash_erase_req_o(flash_erase_req_o),
      .erase_number_o(erase_number_o), .write_enabled_o(write_enabled_o),
      .unlock_busy_o(unlock_busy_o));
   // Page variant shares every input; only its page number is compared
   wire [9:0] page_number;
   flash_unlock #(.PAGE_WORDS(32), .ADDR_HIGH_BITS(5)) DUT_PAGE (.clock_i(clock_i),
      .resetn_i(resetn_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
      .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(), .sfr_rvalid_o(),
      .low_speed_internal_osc_i(low_speed_internal_osc_i), .flash_done_i(flash_done_i),
      .flash_write_req_o(), .flash_erase_req_o(), .erase_number_o(page_number),
      .write_enabled_o(), .unlock_busy_o());
   task print_verdict;
      if (n_mismatch == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input [9:0] got, input [9:0] exp);
      n_tests = n_tests + 1;
      if (got !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      @(posedge clock_i);
      sfr_wr_i <= 1'b1;
      sfr_addr_i <= a;
      sfr_wdata_i <= d;
      @(posedge clock_i);
      sfr_wr_i <= 1'b0;
      sfr_wdata_i <= ~d;
   endtask
   task rd(input [7:0] a, input [7:0] e);
      @(posedge clock_i);
      sfr_rd_i <= 1'b1;
      sfr_addr_i <= a;
      q.push_back(e);
      @(posedge clock_i);
      sfr_rd_i <= 1'b0;
   endtask
   // Pattern byte number bad-2 is flipped; bad outside 2..7 sends it clean
   task unlock(input integer bad);
      for (i = 2; i < 8; i = i + 1)
         wr({5'h0B, i[2:0]}, PAT[63 - 8 * i -: 8] ^ {7'h00, i == bad});
   endtask
   task cmd(input [7:0] d, input w, input e);
      wr(8'h50, d);
      // The request pulse stands only in the cycle after the write edge
      #1;
      chk(flash_write_req_o, w);
      chk(flash_erase_req_o, e);
      @(posedge clock_i) flash_done_i <= 1'b1;
      @(posedge clock_i) flash_done_i <= 1'b0;
   endtask
   always @(posedge clock_i)
      if (sfr_rvalid_o === 1'b1) chk(sfr_rdata_o, q.size() ? q.pop_front() : 10'h3FF);
   initial begin
      repeat (5000) @(posedge clock_i);
      n_mismatch = n_mismatch + 1;
      print_verdict;
   end
   initial begin
      v = $urandom(48);
      repeat (4) @(posedge clock_i);
      resetn_i <= 1'b1;
      rd(8'h50, 8'h70);
      rd(8'h55, 8'h00);
      rd(8'h60, 8'h00);
      for (i = 0; i < 8; i = i + 1) rd({5'h0B, i[2:0]}, 8'h00);
      for (i = 0; i < 8; i = i + 1) begin
         v = $urandom;
         wr({5'h0B, i[2:0]}, v);
         rd({5'h0B, i[2:0]}, v);
      end
      wr(8'h50, 8'hF0);
      rd(8'h50, 8'h70);
      wr(8'h50, 8'h68);
      rd(8'h50, 8'h68);
      unlock(3);
      rd(8'h50, 8'h60);
      chk(write_enabled_o, 1'b0);
      wr(8'h50, 8'h68);
      repeat (250) @(posedge clock_i);
      chk(unlock_busy_o, 1'b0);
      unlock(9);
      rd(8'h50, 8'h60);
      wr(8'h50, 8'h68);
      unlock(9);
      rd(8'h50, 8'hE0);
      chk(write_enabled_o, 1'b1);
      v = $urandom;
      h = $urandom;
      wr(8'h54, v);
      wr(8'h55, h);
      @(posedge clock_i);
      #1;
      chk(erase_number_o, {6'h00, h[3:0]});
      chk(page_number, {2'b00, h[4:0], v[7:5]});
      // Erase first so the write lands in a cleared block
      cmd(8'h94, 1'b0, 1'b1);
      cmd(8'h84, 1'b1, 1'b0);
      rd(8'h50, 8'h80);
      wr(8'h50, 8'h00);
      rd(8'h50, 8'h00);
      chk(write_enabled_o, 1'b0);
      cmd(8'h84, 1'b0, 1'b0);
      rd(8'h50, 8'h00);
      repeat (4) @(posedge clock_i);
      print_verdict;
   end
endmodule
